// File: shared/oasr_pkg.sv
// Purpose: Shared types and constants of the operand and address size resolver.
// Assumes: One core clock; software reaches the control word over classic Wishbone.
// Notes:   Every offset, field position and reset value used by the logic lives here.
package oasr_pkg;

    // ************************************************************
    // Register map, field positions and reset values
    // ************************************************************
    localparam int WB_AW = 8;
    localparam logic [WB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [WB_AW-1:0] OFS_STAT = 8'h04;
    localparam logic [WB_AW-1:0] OFS_CNT = 8'h08;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_D_BIT = 2;
    localparam int CTRL_L_BIT = 3;
    localparam int STAT_OPSZ_LSB = 0;
    localparam int STAT_ADSZ_LSB = 2;
    localparam int STAT_ERR_BIT = 4;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;

    // ************************************************************
    // Prefix fields and register numbers
    // ************************************************************
    localparam int EXT_FIELD_W = 4;
    localparam int WIDE_OP_BIT = 3;
    localparam logic [3:0] GPR_A = 4'h0;
    localparam logic [3:0] GPR_D = 4'h2;
    localparam logic [3:0] HI_BYTE_OFS = 4'h4;
    localparam logic [3:0] CR_EXTRA = 4'h8;
    localparam logic [63:0] OFS_MASK16 = 64'h0000_0000_0000_ffff;
    localparam logic [63:0] OFS_MASK32 = 64'h0000_0000_ffff_ffff;
    localparam logic [63:0] OFS_MASK64 = 64'hffff_ffff_ffff_ffff;

    // ************************************************************
    // Enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_REAL = 2'b00,
        MODE_PROT = 2'b01,
        MODE_V86 = 2'b10,
        MODE_SYS_MGMT = 2'b11
    } oasr_mode_t;

    typedef enum logic [1:0] {
        SZ8 = 2'b00,
        SZ16 = 2'b01,
        SZ32 = 2'b10,
        SZ64 = 2'b11
    } oasr_size_t;

    typedef enum logic [1:0] {
        OPC_PLAIN = 2'b00,
        OPC_ARITH = 2'b01,
        OPC_DIVIDE = 2'b10,
        OPC_PAIR = 2'b11
    } oasr_opc_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic pfx_66;
        logic pfx_67;
        logic pfx_ext;
        logic [EXT_FIELD_W-1:0] ext;
        logic simd_mand;
        oasr_opc_t opc;
        logic imm_present;
        logic imm_wide;
        logic byte_op;
        logic reg8_used;
        logic [3:0] reg8_idx;
        logic [3:0] vec_idx;
        logic cr_acc;
        logic [3:0] cr_idx;
    } oasr_insn_t;

    typedef struct packed {
        logic valid;
        oasr_size_t op_size;
        oasr_size_t addr_size;
        logic [63:0] ofs_mask;
        logic [3:0] reg8_idx;
        logic reg8_high;
        logic [3:0] pair_hi;
        logic [3:0] pair_lo;
        logic pair_128;
        logic illegal;
    } oasr_res_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_AW-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } oasr_wbm_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } oasr_wbs_t;

endpackage

// File: rtl/oasr_resolver.sv
// Purpose: Resolve effective operand and address size of each decoded instruction.
// Assumes: Prefix scan delivers one instruction per cycle on the core clock.
// Notes:   The result is registered, leaving this stage one edge after it entered.
//
// Added by the designer: the register offsets and the Wishbone slave port.

// Function
// (RULE_01) Protected mode: default-size flag set gives 32-bit defaults, clear gives 16.
// (RULE_02) Real, virtual-8086 and system management mode always default to 16 bits.
// (RULE_03) 16-bit attribute allows 8/16-bit operands, 32-bit attribute allows 8/32.
// (RULE_04) 16-bit address attribute makes offsets and displacements 16 bits wide.
// (RULE_05) 32-bit address attribute makes offsets and displacements 32 bits wide.
// (RULE_06) Size prefixes affect only their own instruction; next one uses defaults.
// (RULE_07) Outside 64-bit mode, 66H flips operand size against the default flag.
// (RULE_08) Outside 64-bit mode, 67H flips address size against the default flag.
// (RULE_09) 64-bit mode defaults: 64-bit addresses, 32-bit operands.
// (RULE_10) 64-bit mode never gives 16-bit addresses; 67H selects 32 bits.
// (RULE_11) 64-bit mode with the wide operand bit gives 64-bit operands.
// (RULE_12) 66H alone gives 16-bit operands; wide operand bit overrides 66H.
// (RULE_13) Register extension prefix is a 4-bit field holding the wide bit.
// (RULE_14) Mandatory SIMD 66H/F2H/F3H never change operand size.
// (RULE_15) Immediates allowed except on divides and never beyond a doubleword.
// (RULE_16) Register pair: high half from first named register, low from second.
// (RULE_17) Long mode: new low bytes need extension prefix, legacy high bytes forbid it.
// (RULE_18) Long mode offers sixteen vector registers, control register 8, 128-bit pair.
// (RULE_19) Sizes leave together with the decoded instruction in the same cycle.
module oasr_resolver
    import oasr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Instruction from prefix scan.
    input wire oasr_insn_t insn_in,
    // Resolved instruction to execute stages.
    output oasr_res_t res_out,
    // Wishbone register port.
    input wire oasr_wbm_t wb_in,
    output oasr_wbs_t wb_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        oasr_mode_t mode;
        logic cs_d;
        logic cs_l;
        logic err;
        logic [31:0] cnt;
        oasr_res_t res;
        oasr_wbs_t wbs;
    } oasr_state_t;

    oasr_state_t s_q;
    oasr_state_t s_d;

    // ************************************************************
    // Size resolution
    // ************************************************************
    logic long_m;
    logic def32;
    logic ext_v;
    logic wide;
    logic o66;
    logic reg8_bad;
    logic vec_bad;
    logic cr_bad;
    logic imm_bad;
    oasr_size_t op_sz;
    oasr_size_t ad_sz;

    // Mode qualifiers; the long flag counts only in protected mode.
    always_comb begin
        long_m = (s_q.mode == MODE_PROT) && s_q.cs_l; // RULE_09
        def32 = (s_q.mode == MODE_PROT) && s_q.cs_d; // RULE_01 RULE_02
        ext_v = long_m && insn_in.pfx_ext; // RULE_13
        wide = ext_v && insn_in.ext[WIDE_OP_BIT]; // RULE_11
        o66 = insn_in.pfx_66 && !insn_in.simd_mand; // RULE_14
    end

    // Sizes derive only from mode, D, L and this instruction's own fields, never from earlier instructions.
    always_comb begin
        if (long_m) begin
            ad_sz = insn_in.pfx_67 ? SZ32 : SZ64; // RULE_10
            if (wide) begin
                op_sz = SZ64; // RULE_12
            end else if (o66) begin
                op_sz = SZ16; // RULE_12
            end else begin
                op_sz = SZ32; // RULE_09
            end
        end else begin
            op_sz = (def32 ^ o66) ? SZ32 : SZ16; // RULE_07 RULE_06
            ad_sz = (def32 ^ insn_in.pfx_67) ? SZ32 : SZ16; // RULE_08 RULE_06
        end
        if (insn_in.byte_op) begin
            op_sz = SZ8; // RULE_03
        end
    end

    // Legality checks; a bad encoding is flagged, not silently repaired.
    always_comb begin
        reg8_bad = 1'b0;
        if (insn_in.reg8_used && !ext_v && insn_in.reg8_idx[3]) begin
            reg8_bad = 1'b1; // RULE_17
        end
        vec_bad = !long_m && insn_in.vec_idx[3]; // RULE_18
        cr_bad = insn_in.cr_acc && !long_m && (insn_in.cr_idx == CR_EXTRA); // RULE_18
        imm_bad = insn_in.imm_present && ((insn_in.opc == OPC_DIVIDE) || insn_in.imm_wide); // RULE_15
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        // Result stage register: one instruction in, one out per cycle.
        s_d.res.valid = insn_in.valid; // RULE_19
        if (insn_in.valid) begin
            s_d.res.op_size = op_sz;
            s_d.res.addr_size = ad_sz;
            if (ad_sz == SZ16) begin
                s_d.res.ofs_mask = OFS_MASK16; // RULE_04
            end else if (ad_sz == SZ32) begin
                s_d.res.ofs_mask = OFS_MASK32; // RULE_05
            end else begin
                s_d.res.ofs_mask = OFS_MASK64;
            end
            // Without the prefix, numbers 4 to 7 name the legacy high bytes.
            if (!ext_v && (insn_in.reg8_idx[3:2] == 2'b01)) begin
                s_d.res.reg8_high = insn_in.reg8_used; // RULE_17
                s_d.res.reg8_idx = insn_in.reg8_idx - HI_BYTE_OFS;
            end else begin
                s_d.res.reg8_high = 1'b0; // RULE_17
                s_d.res.reg8_idx = insn_in.reg8_idx;
            end
            s_d.res.pair_hi = (insn_in.opc == OPC_PAIR) ? GPR_D : GPR_A; // RULE_16
            s_d.res.pair_lo = GPR_A; // RULE_16
            s_d.res.pair_128 = (insn_in.opc == OPC_PAIR) && wide; // RULE_18
            s_d.res.illegal = reg8_bad || vec_bad || cr_bad || imm_bad;
            s_d.cnt = s_q.cnt + CNT_ONE;
        end
        // Wishbone slave: ack rises one cycle after the request, then drops.
        s_d.wbs.ack = wb_in.cyc && wb_in.stb && !s_q.wbs.ack;
        s_d.wbs.dat = '0;
        if (wb_in.cyc && wb_in.stb && !s_q.wbs.ack) begin
            if (wb_in.adr == OFS_CTRL) begin
                s_d.wbs.dat[CTRL_MODE_LSB +: 2] = s_q.mode;
                s_d.wbs.dat[CTRL_D_BIT] = s_q.cs_d;
                s_d.wbs.dat[CTRL_L_BIT] = s_q.cs_l;
                if (wb_in.we && wb_in.sel[0]) begin
                    s_d.mode = oasr_mode_t'(wb_in.dat[CTRL_MODE_LSB +: 2]);
                    s_d.cs_d = wb_in.dat[CTRL_D_BIT];
                    s_d.cs_l = wb_in.dat[CTRL_L_BIT];
                end
            end else if (wb_in.adr == OFS_STAT) begin
                s_d.wbs.dat[STAT_OPSZ_LSB +: 2] = s_q.res.op_size;
                s_d.wbs.dat[STAT_ADSZ_LSB +: 2] = s_q.res.addr_size;
                s_d.wbs.dat[STAT_ERR_BIT] = s_q.err;
                if (wb_in.we && wb_in.sel[0] && wb_in.dat[STAT_ERR_BIT]) begin
                    s_d.err = 1'b0;
                end
            end else if (wb_in.adr == OFS_CNT) begin
                s_d.wbs.dat = s_q.cnt;
            end
        end
        // Sticky error; a new bad instruction wins over a clear in the same cycle.
        if (s_q.res.valid && s_q.res.illegal) begin
            s_d.err = 1'b1;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.mode <= MODE_REAL;
            s_q.cnt <= CNT_RST;
            s_q.res.op_size <= SZ16;
            s_q.res.addr_size <= SZ16;
            s_q.res.ofs_mask <= OFS_MASK16;
        end else begin
            s_q <= s_d;
        end
    end

    assign res_out = s_q.res;
    assign wb_out = s_q.wbs;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    legacy_default_a: assert property ( // RULE_02
        insn_in.valid && s_q.mode != MODE_PROT && !insn_in.pfx_66 && !insn_in.pfx_67
        && !insn_in.byte_op && !(wb_in.cyc && wb_in.we)
        |=> res_out.op_size == SZ16 && res_out.addr_size == SZ16)
        else $error("legacy mode default is not 16 bits");

    prot_default_a: assert property ( // RULE_01
        insn_in.valid && s_q.mode == MODE_PROT && !s_q.cs_l && !insn_in.pfx_66
        && !insn_in.pfx_67 && !insn_in.byte_op
        |=> res_out.op_size == ($past(s_q.cs_d) ? SZ32 : SZ16)
        && res_out.addr_size == ($past(s_q.cs_d) ? SZ32 : SZ16))
        else $error("protected default size wrong");

    op_flip_a: assert property ( // RULE_07
        insn_in.valid && !long_m && insn_in.pfx_66 && !insn_in.simd_mand
        && !insn_in.byte_op
        |=> res_out.op_size == ($past(def32) ? SZ16 : SZ32))
        else $error("operand prefix did not flip size");

    addr_flip_a: assert property ( // RULE_08
        insn_in.valid && !long_m && insn_in.pfx_67
        |=> res_out.addr_size == ($past(def32) ? SZ16 : SZ32)
        && res_out.ofs_mask == ($past(def32) ? OFS_MASK16 : OFS_MASK32))
        else $error("address prefix did not flip size");

    long_addr_a: assert property ( // RULE_10
        insn_in.valid && long_m
        |=> res_out.addr_size != SZ16
        && res_out.addr_size == ($past(insn_in.pfx_67) ? SZ32 : SZ64))
        else $error("long mode address size wrong");

    wide_wins_a: assert property ( // RULE_12
        insn_in.valid && wide && !insn_in.byte_op |=> res_out.op_size == SZ64)
        else $error("wide bit did not give 64-bit operands");

    simd_pfx_a: assert property ( // RULE_14
        insn_in.valid && insn_in.simd_mand && !insn_in.byte_op && long_m && !wide
        |=> res_out.op_size == SZ32)
        else $error("mandatory prefix changed size");

    one_shot_a: assert property ( // RULE_06
        insn_in.valid && !insn_in.pfx_66 && !insn_in.byte_op && !long_m
        ##1 insn_in.valid && !insn_in.pfx_66 && !insn_in.byte_op && $stable(def32)
        && $stable(long_m)
        |=> res_out.op_size == $past(res_out.op_size))
        else $error("prefix leaked into next instruction");

    divide_imm_a: assert property ( // RULE_15
        insn_in.valid && insn_in.imm_present && insn_in.opc == OPC_DIVIDE
        |=> res_out.illegal ##1 s_q.err)
        else $error("divide immediate not flagged");

    high_byte_a: assert property ( // RULE_17
        insn_in.valid && insn_in.reg8_used && ext_v |=> !res_out.reg8_high)
        else $error("high byte chosen with extension prefix");

    pair_a: assert property ( // RULE_16
        insn_in.valid && insn_in.opc == OPC_PAIR
        |=> res_out.pair_hi == GPR_D && res_out.pair_lo == GPR_A)
        else $error("register pair order wrong");

    wb_ack_a: assert property (
        wb_in.cyc && wb_in.stb && !wb_out.ack |=> wb_out.ack ##1 !wb_out.ack)
        else $error("wishbone ack timing wrong");

    valid_a: assert property ( // RULE_19
        insn_in.valid |=> res_out.valid)
        else $error("result valid missing");

    long_wide_c: cover property (insn_in.valid && wide && insn_in.pfx_66);
    prot_flip_c: cover property (insn_in.valid && def32 && insn_in.pfx_67);
    err_c: cover property (s_q.err ##[1:4] !s_q.err);
    wb_c: cover property (wb_in.cyc && wb_in.we ##[1:3] wb_out.ack);

endmodule // oasr_resolver

// File: tb/oasr_scan_model.sv
// Purpose: Prefix scan stage model feeding the size resolver.
// Assumes: Requests change just after the rising edge of the core clock.
// Notes:   Idle cycles drive inverted fields, so stale values are never trusted.
module oasr_scan_model
    import oasr_pkg::*;
(
    // Clock.
    input wire logic clk_sys_in,
    // Instruction towards the resolver.
    output oasr_insn_t insn_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Nothing is offered until the first call.
    initial begin
        insn_out = '0;
    end

    // Present one instruction from the next rising edge; it stays until the next call.
    task automatic send(input oasr_insn_t i);
        @(posedge clk_sys_in);
        insn_out <= i;
    endtask

    // Release the request; a real scan stage keeps no promise about idle fields.
    task automatic idle();
        @(posedge clk_sys_in);
        insn_out <= {1'b0, ~insn_out[$bits(oasr_insn_t)-2:0]};
    endtask
endmodule // oasr_scan_model

// File: tb/oasr_resolver_test.sv
// Purpose: Self-checking bench of the operand and address size resolver.
// Assumes: Control word is written over classic Wishbone before each group.
// Notes:   Expected sizes are worked out here from mode, flags and prefixes.
module oasr_resolver_test
    import oasr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic rst_n;
    oasr_insn_t insn;
    oasr_res_t res;
    oasr_wbm_t wbm;
    oasr_wbs_t wbs;
    int err_total;
    int n_tests;
    int ninsn;

    oasr_resolver u_oasr_resolver(.clk_sys_in(clk_sys), .rst_n_in(rst_n), .insn_in(insn),
        .res_out(res), .wb_in(wbm), .wb_out(wbs));
    oasr_scan_model u_oasr_scan_model(.clk_sys_in(clk_sys), .insn_out(insn));

    // ************************************************************
    // Clock, verdict and comparisons
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic [63:0] msk(input oasr_size_t s);
        return (s == SZ16) ? OFS_MASK16 : ((s == SZ32) ? OFS_MASK32 : OFS_MASK64);
    endfunction

    task automatic chk_res(input oasr_size_t op, input oasr_size_t ad, input logic ill);
        chk("result valid", 64'h1, 64'(res.valid));
        chk("operand size", 64'(op), 64'(res.op_size));
        chk("address size", 64'(ad), 64'(res.addr_size));
        chk("offset mask", msk(ad), res.ofs_mask);
        chk("illegal", 64'(ill), 64'(res.illegal));
    endtask

    // ************************************************************
    // Access tasks
    // ************************************************************
    // Classic cycle: hold everything until ack is sampled, then release.
    task automatic wb(input logic we, input logic [WB_AW-1:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        @(posedge clk_sys);
        wbm <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        do @(posedge clk_sys); while (wbs.ack !== 1'b1);
        rd = wbs.dat;
        wbm <= '0;
    endtask

    task automatic setm(input oasr_mode_t m, input logic d, input logic l);
        logic [31:0] rd;
        wb(1'b1, OFS_CTRL, {28'h0, l, d, m}, rd);
    endtask

    task automatic run(input oasr_insn_t i, input oasr_size_t op, input oasr_size_t ad,
                       input logic ill);
        u_oasr_scan_model.send(i);
        u_oasr_scan_model.idle();
        #1;
        chk_res(op, ad, ill);
        ninsn++;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [31:0] rd;
        logic w;
        oasr_insn_t base;
        oasr_insn_t b;
        err_total = 0;
        n_tests = 0;
        ninsn = 0;
        rst_n = 1'b0;
        wbm = '0;
        base = '0;
        base.valid = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk("reset op", 64'(SZ16), 64'(res.op_size));
        chk("reset mask", OFS_MASK16, res.ofs_mask);
        wb(1'b0, OFS_CTRL, 32'h0, rd);
        chk("ctrl reset", 64'h0, 64'(rd));
        // Legacy modes ignore both descriptor flags.
        for (int m = 0; m < 4; m++) begin
            if (m != 1) begin
                setm(oasr_mode_t'(m), 1'b1, 1'b1);
                run(base, SZ16, SZ16, 1'b0);
            end
        end
        // Protected mode: every D, 66H, 67H combination.
        for (int k = 0; k < 8; k++) begin
            b = base;
            {w, b.pfx_66, b.pfx_67} = 3'(k);
            setm(MODE_PROT, w, 1'b0);
            run(b, (w ^ b.pfx_66) ? SZ32 : SZ16, (w ^ b.pfx_67) ? SZ32 : SZ16, 1'b0);
        end
        // Long mode with D set, so a flip against D would wrongly give 16.
        setm(MODE_PROT, 1'b1, 1'b1);
        for (int k = 0; k < 8; k++) begin
            b = base;
            {w, b.pfx_66, b.pfx_67} = 3'(k);
            b.pfx_ext = 1'b1;
            b.ext = {w, 3'h5};
            run(b, w ? SZ64 : (b.pfx_66 ? SZ16 : SZ32), b.pfx_67 ? SZ32 : SZ64, 1'b0);
        end
        b = base;
        b.byte_op = 1'b1;
        b.reg8_used = 1'b1;
        b.reg8_idx = 4'h4;
        run(b, SZ8, SZ64, 1'b0);
        chk("high byte", 64'h1, 64'(res.reg8_high));
        b.pfx_ext = 1'b1;
        run(b, SZ8, SZ64, 1'b0);
        chk("high byte", 64'h0, 64'(res.reg8_high));
        b.pfx_ext = 1'b0;
        b.reg8_idx = 4'h9;
        run(b, SZ8, SZ64, 1'b1);
        b = base;
        b.opc = OPC_PAIR;
        b.pfx_ext = 1'b1;
        b.ext = 4'h8;
        b.vec_idx = 4'hf;
        b.cr_acc = 1'b1;
        b.cr_idx = CR_EXTRA;
        run(b, SZ64, SZ64, 1'b0);
        chk("pair high", 64'(GPR_D), 64'(res.pair_hi));
        chk("pair low", 64'(GPR_A), 64'(res.pair_lo));
        chk("pair 128", 64'h1, 64'(res.pair_128));
        // Same encoding outside long mode loses the wide pair and the extra registers.
        setm(MODE_PROT, 1'b1, 1'b0);
        run(b, SZ32, SZ32, 1'b1);
        chk("pair 128", 64'h0, 64'(res.pair_128));
        b = base;
        b.pfx_66 = 1'b1;
        b.simd_mand = 1'b1;
        run(b, SZ32, SZ32, 1'b0);
        b = base;
        b.opc = OPC_ARITH;
        b.imm_present = 1'b1;
        run(b, SZ32, SZ32, 1'b0);
        b.imm_wide = 1'b1;
        run(b, SZ32, SZ32, 1'b1);
        b.imm_wide = 1'b0;
        b.opc = OPC_DIVIDE;
        run(b, SZ32, SZ32, 1'b1);
        wb(1'b0, OFS_STAT, 32'h0, rd);
        chk("status", 64'h1a, 64'(rd));
        wb(1'b1, OFS_STAT, 32'h1f, rd);
        wb(1'b0, OFS_STAT, 32'h0, rd);
        chk("status cleared", 64'h0a, 64'(rd));
        // Back to back: a prefixed instruction must not leak into the next one.
        setm(MODE_PROT, 1'b0, 1'b0);
        b = base;
        b.pfx_66 = 1'b1;
        b.pfx_67 = 1'b1;
        u_oasr_scan_model.send(b);
        u_oasr_scan_model.send(base);
        #1;
        chk_res(SZ32, SZ32, 1'b0);
        u_oasr_scan_model.idle();
        #1;
        chk_res(SZ16, SZ16, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("valid drop", 64'h0, 64'(res.valid));
        wb(1'b0, OFS_CNT, 32'h0, rd);
        chk("count", 64'(ninsn + 2), 64'(rd));
        wb(1'b1, 8'h0c, 32'hffff_ffff, rd);
        wb(1'b0, 8'h0c, 32'h0, rd);
        chk("unmapped", 64'h0, 64'(rd));
        wb(1'b0, OFS_CTRL, 32'h0, rd);
        chk("ctrl kept", 64'h1, 64'(rd));
        summarize();
    end

    // A hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
endmodule // oasr_resolver_test
